// file: core/tcu_pkg.sv
package tcu_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TMODE  = 8'h00;
  localparam logic [7:0] ADDR_TCTRL  = 8'h04;
  localparam logic [7:0] ADDR_TL0    = 8'h08;
  localparam logic [7:0] ADDR_TH0    = 8'h0c;
  localparam logic [7:0] ADDR_TL1    = 8'h10;
  localparam logic [7:0] ADDR_TH1    = 8'h14;
  localparam logic [7:0] ADDR_TL2    = 8'h18;
  localparam logic [7:0] ADDR_TH2    = 8'h1c;
  localparam logic [7:0] ADDR_RCAPL  = 8'h20;
  localparam logic [7:0] ADDR_RCAPH  = 8'h24;
  localparam logic [7:0] ADDR_T2CTRL = 8'h28;
  localparam logic [7:0] ADDR_T2MODE = 8'h2c;
  localparam logic [7:0] ADDR_SYSCFG = 8'h30;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GATE1_BIT = 7;
  localparam int CT1_BIT   = 6;
  localparam int MODE1_LSB = 4;
  localparam int GATE0_BIT = 3;
  localparam int CT0_BIT   = 2;
  localparam int MODE0_LSB = 0;
  localparam int TF1_BIT   = 7;
  localparam int TR1_BIT   = 6;
  localparam int TF0_BIT   = 5;
  localparam int TR0_BIT   = 4;
  localparam int TF2_BIT   = 7;
  localparam int EXTERNAL_EVENT_FLAG_BIT  = 6;
  localparam int RCLK_BIT  = 5;
  localparam int TCLK_BIT  = 4;
  localparam int EXTERNAL_EVENT_ENABLE_BIT = 3;
  localparam int TR2_BIT   = 2;
  localparam int CT2_BIT   = 1;
  localparam int CPRL2_BIT = 0;
  localparam int CLOCK_OUT_ENABLE_BIT  = 1;
  localparam int DOWN_COUNT_ENABLE_BIT  = 0;
  localparam int SIX_BIT   = 0;
  localparam int T2IE_BIT  = 1;
  localparam int IDLE_BIT  = 2;
  localparam int PDOWN_BIT = 3;
  localparam int EXTM_BIT  = 4;

  // ---------------------------------------------------------------
  // Reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [3:0]  MC_CLK_6    = 4'h6;
  localparam logic [3:0]  MC_CLK_12   = 4'hc;
  localparam logic [15:0] T2_ALL_ONES = 16'hffff;

  typedef enum logic [1:0] {
    TCU_MODE13 = 2'h0,
    TCU_MODE16 = 2'h1,
    TCU_MODE8R = 2'h2,
    TCU_SPLIT  = 2'h3
  } tcu_mode_t;

  typedef enum logic [2:0] {
    TCU_BUS_IDLE = 3'b001,
    TCU_BUS_WR   = 3'b010,
    TCU_BUS_RD   = 3'b100
  } tcu_bus_st_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } tcu_step_t;

  typedef struct packed {
    logic [7:0] idx;
    logic       wr;
  } tcu_addr_t;

endpackage : tcu_pkg

// file: core/tcu_top.sv
// Behaviour
// - clock-out frequency osc over n times span
// - clock-out rollovers set no overflow flag
// - strobes 1 in idle, 0 in power-down
// - counter-select bit and two-bit mode field
// - mode 0 counts 13 bits, low-byte top held
// - wrap to zero sets overflow flag
// - count while run and gate conditions hold
// - gate bits at mode bits 7 and 3
// - mode 1 counts full 16 bits
// - mode 2 low byte reloads from high
// - second timer mode 3 holds count
// - first timer mode 3 splits two bytes
// - second timer runs by leaving mode 3
// - third timer machine cycles or pin edges
// - capture on falling edge, set external flag
// - both third-timer flags share one interrupt; external flag masked while down enable set
// - down enable resets 0, pin sets direction
// - up auto-reload overflows and reloads
// - falling edge also triggers reload
// - up direction overflows and reloads
// - down direction underflows at reload, loads ones
// - external flag toggles, no interrupt
// - clock-out when timer, enabled and running
`timescale 1ns/10ps
`default_nettype none

module tcu_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        t0_count_pin,
  input  wire logic        t1_count_pin,
  input  wire logic        t2_count_pin,
  input  wire logic        external_gate_pin0,
  input  wire logic        external_gate_pin1,
  input  wire logic        capture_direction_pin,
  output logic             clock_out_o,
  output logic             clock_out_oe,
  output logic             overflow_flag0_o,
  output logic             second_overflow_flag_o,
  output logic             third_irq_o,
  output logic             t1_baud_pulse_o,
  output logic             t2_baud_pulse_o,
  output logic             addr_latch_strobe_o,
  output logic             program_store_strobe_o,
  output logic             port0_float_o,
  output logic             port2_addr_o
);

  // ---------------------------------------------------------------
  // Mode-0/1/2/3 step of a two-byte counter
  // ---------------------------------------------------------------
  function automatic tcu_pkg::tcu_step_t step01(input logic [1:0] mode,
                                                input logic [7:0] hi,
                                                input logic [7:0] lo);
    tcu_pkg::tcu_step_t s;
    s.hi  = hi;
    s.lo  = lo;
    s.ovf = 1'b0;
    unique case (mode)
      tcu_pkg::TCU_MODE13: {s.ovf, s.hi, s.lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h1;
      tcu_pkg::TCU_MODE16: {s.ovf, s.hi, s.lo} = {1'b0, hi, lo} + 17'h1;
      tcu_pkg::TCU_MODE8R: begin
        {s.ovf, s.lo} = {1'b0, lo} + 9'h1;
        if (s.ovf) begin
          s.lo = hi;
        end
      end
      tcu_pkg::TCU_SPLIT: {s.ovf, s.lo} = {1'b0, lo} + 9'h1;
    endcase
    return s;
  endfunction : step01

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]  tmode_r;
  logic        tf0_r, tr0_r, tf1_r, tr1_r;
  logic [7:0]  tl0_r, th0_r, tl1_r, th1_r;
  logic [15:0] cnt2_r, rcap_r;
  logic        tf2_r, external_event_flag_r, rclk_r, tclk_r, external_event_enable_r, tr2_r, ct2_r, cprl2_r;
  logic        clock_out_enable_r, down_count_enable_r;
  logic [4:0]  cfg_r;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  tcu_pkg::tcu_bus_st_t bus_st_r;
  tcu_pkg::tcu_addr_t   addr_r;
  logic                 acc;
  logic                 we;
  logic [7:0]           wd;
  logic [7:0]           rd_val;

  assign acc = hsel & hready & htrans[1];
  assign we  = (bus_st_r == tcu_pkg::TCU_BUS_WR);
  assign wd  = hwdata[7:0];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_st_r <= tcu_pkg::TCU_BUS_IDLE;
      addr_r   <= '0;
    end else if (acc) begin
      bus_st_r <= hwrite ? tcu_pkg::TCU_BUS_WR : tcu_pkg::TCU_BUS_RD;
      addr_r   <= '{idx: haddr[7:0], wr: hwrite};
    end else begin
      bus_st_r <= tcu_pkg::TCU_BUS_IDLE;
    end
  end

  // Reads take one wait state so data reflects the previous write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end else begin
      hreadyout <= ~(acc & ~hwrite);
      hresp     <= 1'b0;
      if (bus_st_r == tcu_pkg::TCU_BUS_RD) begin
        hrdata <= {24'h0, rd_val};
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (addr_r.idx)
      tcu_pkg::ADDR_TMODE:  rd_val = tmode_r;
      tcu_pkg::ADDR_TCTRL:  rd_val = {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
      tcu_pkg::ADDR_TL0:    rd_val = tl0_r;
      tcu_pkg::ADDR_TH0:    rd_val = th0_r;
      tcu_pkg::ADDR_TL1:    rd_val = tl1_r;
      tcu_pkg::ADDR_TH1:    rd_val = th1_r;
      tcu_pkg::ADDR_TL2:    rd_val = cnt2_r[7:0];
      tcu_pkg::ADDR_TH2:    rd_val = cnt2_r[15:8];
      tcu_pkg::ADDR_RCAPL:  rd_val = rcap_r[7:0];
      tcu_pkg::ADDR_RCAPH:  rd_val = rcap_r[15:8];
      tcu_pkg::ADDR_T2CTRL: rd_val = {tf2_r, external_event_flag_r, rclk_r, tclk_r,
                                      external_event_enable_r, tr2_r, ct2_r, cprl2_r};
      tcu_pkg::ADDR_T2MODE: rd_val = {6'h0, clock_out_enable_r, down_count_enable_r};
      tcu_pkg::ADDR_SYSCFG: rd_val = {3'h0, cfg_r};
      default:              rd_val = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Machine-cycle and clock-out rate dividers
  // ---------------------------------------------------------------
  logic       six_clk, pdown, idle, extmem, t2ie;
  logic [3:0] mc_cnt_r;
  logic       co_cnt_r;
  logic       mc_tick, co_tick;

  assign six_clk = cfg_r[tcu_pkg::SIX_BIT];
  assign t2ie    = cfg_r[tcu_pkg::T2IE_BIT];
  assign idle    = cfg_r[tcu_pkg::IDLE_BIT];
  assign pdown   = cfg_r[tcu_pkg::PDOWN_BIT];
  assign extmem  = cfg_r[tcu_pkg::EXTM_BIT];

  assign mc_tick = ~pdown & (mc_cnt_r == ((six_clk ? tcu_pkg::MC_CLK_6
                                                   : tcu_pkg::MC_CLK_12) - 4'h1));
  // Clock-out rate: every clock in 6-clock mode, every second in 12-clock
  assign co_tick = ~pdown & (six_clk | co_cnt_r);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mc_cnt_r <= 4'h0;
      co_cnt_r <= 1'b0;
    end else if (!pdown) begin
      mc_cnt_r <= mc_tick ? 4'h0 : mc_cnt_r + 4'h1;
      co_cnt_r <= ~co_cnt_r;
    end
  end

  // ---------------------------------------------------------------
  // Pin falling-edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_q_r;
  logic [3:0] pin_fall;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_q_r <= 4'hf;
    end else begin
      pin_q_r <= {capture_direction_pin, t2_count_pin, t1_count_pin, t0_count_pin};
    end
  end

  assign pin_fall = pin_q_r & ~{capture_direction_pin, t2_count_pin,
                                t1_count_pin, t0_count_pin} & {4{~pdown}};

  // ---------------------------------------------------------------
  // Timers 0 and 1
  // ---------------------------------------------------------------
  logic [1:0]         mode0, mode1;
  logic               split0, run0, run1, inc0, inc1, inc_th0;
  tcu_pkg::tcu_step_t s0, s1;
  logic [8:0]         th0_sum;

  assign mode0  = tmode_r[tcu_pkg::MODE0_LSB +: 2];
  assign mode1  = tmode_r[tcu_pkg::MODE1_LSB +: 2];
  assign split0 = (mode0 == tcu_pkg::TCU_SPLIT);
  assign run0   = tr0_r & (~tmode_r[tcu_pkg::GATE0_BIT] | external_gate_pin0);
  // While timer 0 is split, timer 1 runs without TR1 whenever it is out of mode 3 and its gate allows
  assign run1   = (split0 | tr1_r) & (~tmode_r[tcu_pkg::GATE1_BIT] | external_gate_pin1);
  assign inc0   = run0 & (tmode_r[tcu_pkg::CT0_BIT] ? pin_fall[0] : mc_tick);
  assign inc1   = run1 & (mode1 != tcu_pkg::TCU_SPLIT)
                  & (tmode_r[tcu_pkg::CT1_BIT] ? pin_fall[1] : mc_tick);
  assign inc_th0 = split0 & tr1_r & mc_tick;
  assign s0      = step01(mode0, th0_r, tl0_r);
  assign s1      = step01(mode1, th1_r, tl1_r);
  assign th0_sum = {1'b0, th0_r} + 9'h1;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmode_r <= tcu_pkg::RST_BYTE;
    end else if (we && addr_r.idx == tcu_pkg::ADDR_TMODE) begin
      tmode_r <= wd;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tl0_r <= tcu_pkg::RST_BYTE;
      th0_r <= tcu_pkg::RST_BYTE;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_TL0) begin
        tl0_r <= wd;
      end else if (inc0) begin
        tl0_r <= s0.lo;
      end
      if (we && addr_r.idx == tcu_pkg::ADDR_TH0) begin
        th0_r <= wd;
      end else if (inc_th0) begin
        th0_r <= th0_sum[7:0];
      end else if (inc0 && !split0) begin
        th0_r <= s0.hi;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tl1_r <= tcu_pkg::RST_BYTE;
      th1_r <= tcu_pkg::RST_BYTE;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_TL1) begin
        tl1_r <= wd;
      end else if (inc1) begin
        tl1_r <= s1.lo;
      end
      if (we && addr_r.idx == tcu_pkg::ADDR_TH1) begin
        th1_r <= wd;
      end else if (inc1) begin
        th1_r <= s1.hi;
      end
    end
  end

  // Run bits are plain storage; setting one leaves the counts alone
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tr0_r <= 1'b0;
      tr1_r <= 1'b0;
      tf0_r <= 1'b0;
      tf1_r <= 1'b0;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_TCTRL) begin
        tr0_r <= wd[tcu_pkg::TR0_BIT];
        tr1_r <= wd[tcu_pkg::TR1_BIT];
      end
      // Hardware set wins over a software clear in the same cycle
      tf0_r <= ((we && addr_r.idx == tcu_pkg::ADDR_TCTRL) ? wd[tcu_pkg::TF0_BIT] : tf0_r)
               | (inc0 & s0.ovf);
      tf1_r <= ((we && addr_r.idx == tcu_pkg::ADDR_TCTRL) ? wd[tcu_pkg::TF1_BIT] : tf1_r)
               | (split0 ? (inc_th0 & th0_sum[8]) : (inc1 & s1.ovf));
    end
  end

  // ---------------------------------------------------------------
  // Timer 2
  // ---------------------------------------------------------------
  logic        baud2, cap2, updn2, clkout2, dir_up, inc2, ex_fall;
  logic [15:0] cnt2_nxt;
  logic        ovf2, ex_evt;

  assign baud2   = rclk_r | tclk_r;
  assign cap2    = cprl2_r & ~baud2;
  assign updn2   = ~cap2 & ~baud2 & down_count_enable_r;
  assign clkout2 = ~ct2_r & clock_out_enable_r & tr2_r;
  assign dir_up  = ~updn2 | capture_direction_pin;
  assign inc2    = tr2_r & (ct2_r ? pin_fall[2]
                                  : ((baud2 | clkout2) ? co_tick : mc_tick));
  assign ex_fall = external_event_enable_r & pin_fall[3] & ~updn2;

  always_comb begin
    cnt2_nxt = cnt2_r;
    ovf2     = 1'b0;
    ex_evt   = 1'b0;
    if (inc2) begin
      if (dir_up) begin
        if (cnt2_r == tcu_pkg::T2_ALL_ONES) begin
          ovf2     = 1'b1;
          cnt2_nxt = cap2 ? 16'h0000 : rcap_r;
        end else begin
          cnt2_nxt = cnt2_r + 16'h0001;
        end
      end else if (cnt2_r == rcap_r) begin
        ovf2     = 1'b1;
        cnt2_nxt = tcu_pkg::T2_ALL_ONES;
      end else begin
        cnt2_nxt = cnt2_r - 16'h0001;
      end
    end
    if (ex_fall) begin
      ex_evt = 1'b1;
      if (!cap2 && !baud2) begin
        cnt2_nxt = rcap_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt2_r <= 16'h0000;
    end else begin
      cnt2_r <= cnt2_nxt;
      if (we && addr_r.idx == tcu_pkg::ADDR_TL2) begin
        cnt2_r[7:0] <= wd;
      end
      if (we && addr_r.idx == tcu_pkg::ADDR_TH2) begin
        cnt2_r[15:8] <= wd;
      end
    end
  end

  // Capture overrides a software write to the same byte
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rcap_r <= 16'h0000;
    end else if (ex_evt && cap2) begin
      rcap_r <= cnt2_r;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_RCAPL) begin
        rcap_r[7:0] <= wd;
      end
      if (we && addr_r.idx == tcu_pkg::ADDR_RCAPH) begin
        rcap_r[15:8] <= wd;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {rclk_r, tclk_r, external_event_enable_r, tr2_r, ct2_r, cprl2_r} <= 6'h00;
      tf2_r  <= 1'b0;
      external_event_flag_r <= 1'b0;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_T2CTRL) begin
        {rclk_r, tclk_r, external_event_enable_r, tr2_r, ct2_r, cprl2_r} <= wd[5:0];
      end
      tf2_r <= ((we && addr_r.idx == tcu_pkg::ADDR_T2CTRL) ? wd[tcu_pkg::TF2_BIT] : tf2_r)
               | (ovf2 & ~baud2 & ~clkout2);
      if (ovf2 && updn2) begin
        external_event_flag_r <= ~external_event_flag_r;
      end else begin
        external_event_flag_r <= ((we && addr_r.idx == tcu_pkg::ADDR_T2CTRL) ? wd[tcu_pkg::EXTERNAL_EVENT_FLAG_BIT]
                                                               : external_event_flag_r)
                  | ex_evt;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_out_enable_r <= 1'b0;
      down_count_enable_r <= 1'b0;
      cfg_r  <= 5'h00;
    end else begin
      if (we && addr_r.idx == tcu_pkg::ADDR_T2MODE) begin
        clock_out_enable_r <= wd[tcu_pkg::CLOCK_OUT_ENABLE_BIT];
        down_count_enable_r <= wd[tcu_pkg::DOWN_COUNT_ENABLE_BIT];
      end
      if (we && addr_r.idx == tcu_pkg::ADDR_SYSCFG) begin
        cfg_r <= wd[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_out_o  <= 1'b0;
      clock_out_oe <= 1'b0;
    end else begin
      clock_out_oe <= clkout2;
      if (!clkout2) begin
        clock_out_o <= 1'b0;
      end else if (ovf2) begin
        clock_out_o <= ~clock_out_o;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      overflow_flag0_o       <= 1'b0;
      second_overflow_flag_o <= 1'b0;
      third_irq_o            <= 1'b0;
      t1_baud_pulse_o        <= 1'b0;
      t2_baud_pulse_o        <= 1'b0;
    end else begin
      overflow_flag0_o       <= tf0_r;
      second_overflow_flag_o <= tf1_r;
      third_irq_o            <= t2ie & (tf2_r | (external_event_flag_r & ~down_count_enable_r));
      t1_baud_pulse_o        <= inc1 & s1.ovf;
      t2_baud_pulse_o        <= ovf2 & (baud2 | clkout2);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_latch_strobe_o    <= 1'b1;
      program_store_strobe_o <= 1'b1;
      port0_float_o          <= 1'b0;
      port2_addr_o           <= 1'b0;
    end else begin
      addr_latch_strobe_o    <= ~pdown;
      program_store_strobe_o <= ~pdown;
      port0_float_o          <= extmem & (idle | pdown);
      port2_addr_o           <= extmem & idle & ~pdown;
    end
  end

endmodule : tcu_top

`default_nettype wire

// file: verif/tcu_top_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none

module tcu_top_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        clock_out_o,
  input wire logic        clock_out_oe,
  input wire logic        t1_baud_pulse_o,
  input wire logic        t2_baud_pulse_o,
  input wire logic        addr_latch_strobe_o,
  input wire logic        program_store_strobe_o,
  input wire logic        port0_float_o,
  input wire logic        port2_addr_o
);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait: assert property (rd_take |=> rd_answer)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_strobe_pair: assert property (addr_latch_strobe_o == program_store_strobe_o)
    else $error("strobes differ");
  chk_port2_idle: assert property (port2_addr_o |-> port0_float_o && addr_latch_strobe_o)
    else $error("port status wrong in idle");
  chk_out_quiet: assert property (!clock_out_oe |-> !clock_out_o)
    else $error("clock out high while inactive");
  chk_out_rise: assert property ($rose(clock_out_o) |-> clock_out_oe)
    else $error("clock out rose while inactive");
  chk_out_toggle: assert property (t2_baud_pulse_o && clock_out_oe |-> $changed(clock_out_o))
    else $error("clock out missed a rollover");
  chk_baud_single: assert property (t1_baud_pulse_o |=> !t1_baud_pulse_o)
    else $error("baud pulse too long");
endmodule : tcu_top_chk

bind tcu_top tcu_top_chk u_chk (.clk_sys, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .clock_out_o, .clock_out_oe, .t1_baud_pulse_o, .addr_latch_strobe_o,
  .program_store_strobe_o, .port0_float_o, .port2_addr_o, .t2_baud_pulse_o);

`default_nettype wire

// file: verif/tcu_pins.sv
`timescale 1ns/10ps
`default_nettype none

module tcu_pins (
  input  wire logic clk_sys,
  output logic      t0_count_pin,
  output logic      t1_count_pin,
  output logic      t2_count_pin,
  output logic      external_gate_pin0,
  output logic      external_gate_pin1,
  output logic      capture_direction_pin
);
  // ---------------------------------------------------------------
  // Count, gate and capture pins
  // ---------------------------------------------------------------
  initial begin
    t0_count_pin          = 1'b1;
    t1_count_pin          = 1'b1;
    t2_count_pin          = 1'b1;
    external_gate_pin0    = 1'b0;
    external_gate_pin1    = 1'b0;
    capture_direction_pin = 1'b1;
  end

  task t0_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      t0_count_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t0_count_pin <= 1'b1;
    end
  endtask : t0_edges

  task gate0(input logic v);
    @(posedge clk_sys);
    external_gate_pin0 <= v;
  endtask : gate0

  // Leaves the pin low, which also selects down counting
  task ex_fall();
    @(posedge clk_sys);
    capture_direction_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    capture_direction_pin <= 1'b0;
  endtask : ex_fall
endmodule : tcu_pins

`default_nettype wire

// file: verif/three_timer_counter_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none

module three_timer_counter_unit_bench;
  logic        clk_sys, nrst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        t0_count_pin, t1_count_pin, t2_count_pin, external_gate_pin0;
  logic        external_gate_pin1, capture_direction_pin, clock_out_o, clock_out_oe;
  logic        overflow_flag0_o, second_overflow_flag_o, third_irq_o, t1_baud_pulse_o;
  logic        t2_baud_pulse_o, addr_latch_strobe_o, program_store_strobe_o;
  logic        port0_float_o, port2_addr_o;
  int          miscompares = 0, checks_done = 0, cyc = 0, t_a;
  logic [7:0]  rd, prev;
  logic [7:0]  pw [4] = '{8'h14, 8'h18, 8'h04, 8'h08};
  logic [3:0]  pe [4] = '{4'hf, 4'h2, 4'hc, 4'h0};

  tcu_top u_dut (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .t0_count_pin, .t1_count_pin, .t2_count_pin,
    .external_gate_pin0, .external_gate_pin1, .capture_direction_pin, .clock_out_o,
    .clock_out_oe, .overflow_flag0_o, .second_overflow_flag_o, .third_irq_o, .t1_baud_pulse_o,
    .t2_baud_pulse_o, .addr_latch_strobe_o, .program_store_strobe_o, .port0_float_o,
    .port2_addr_o);
  tcu_pins u_pins (.clk_sys, .t0_count_pin, .t1_count_pin, .t2_count_pin, .external_gate_pin0,
    .external_gate_pin1, .capture_direction_pin);

  // ---------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus

  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdc

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    nrst  = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TCTRL, 8'h00);
    rdc(tcu_pkg::ADDR_T2MODE, 8'h00);
    rdc(8'h3c, 8'h00);
    chk({7'h0, addr_latch_strobe_o & program_store_strobe_o}, 8'h01);
    wr(tcu_pkg::ADDR_TMODE, 8'h05);
    wr(tcu_pkg::ADDR_TCTRL, 8'h10);
    u_pins.t0_edges(3);
    rdc(tcu_pkg::ADDR_TL0, 8'h03);
    wr(tcu_pkg::ADDR_TCTRL, 8'h00);
    wr(tcu_pkg::ADDR_TMODE, 8'h08);
    wr(tcu_pkg::ADDR_TL0, 8'hff);
    wr(tcu_pkg::ADDR_TH0, 8'hff);
    wr(tcu_pkg::ADDR_TCTRL, 8'h10);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TL0, 8'hff);
    u_pins.gate0(1'b1);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TH0, 8'h00);
    bus(1'b0, tcu_pkg::ADDR_TL0, 8'h00);
    chk({5'h0, rd[7:5]}, 8'h07);
    rdc(tcu_pkg::ADDR_TCTRL, 8'h30);
    chk({7'h0, overflow_flag0_o}, 8'h01);
    wr(tcu_pkg::ADDR_TCTRL, 8'h00);
    wr(tcu_pkg::ADDR_TMODE, 8'h02);
    wr(tcu_pkg::ADDR_TH0, 8'ha5);
    wr(tcu_pkg::ADDR_TL0, 8'hfe);
    wr(tcu_pkg::ADDR_TCTRL, 8'h10);
    repeat (60) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TH0, 8'ha5);
    bus(1'b0, tcu_pkg::ADDR_TL0, 8'h00);
    chk({4'h0, rd[7:4]}, 8'h0a);
    wr(tcu_pkg::ADDR_TCTRL, 8'h00);
    wr(tcu_pkg::ADDR_TL1, 8'hfe);
    wr(tcu_pkg::ADDR_TH1, 8'hff);
    wr(tcu_pkg::ADDR_TMODE, 8'h30);
    wr(tcu_pkg::ADDR_TCTRL, 8'h40);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TL1, 8'hfe);
    wr(tcu_pkg::ADDR_TMODE, 8'h10);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TH1, 8'h00);
    chk({7'h0, second_overflow_flag_o}, 8'h01);
    wr(tcu_pkg::ADDR_TCTRL, 8'h00);
    wr(tcu_pkg::ADDR_TMODE, 8'h13);
    wr(tcu_pkg::ADDR_TH0, 8'hff);
    wr(tcu_pkg::ADDR_TCTRL, 8'h40);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TCTRL, 8'hc0);
    bus(1'b0, tcu_pkg::ADDR_TL1, 8'h00);
    prev = rd;
    repeat (30) @(posedge clk_sys);
    bus(1'b0, tcu_pkg::ADDR_TL1, 8'h00);
    chk({7'h0, rd !== prev}, 8'h01);
    wr(tcu_pkg::ADDR_SYSCFG, 8'h02);
    wr(tcu_pkg::ADDR_TH2, 8'h12);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h0d);
    repeat (20) @(posedge clk_sys);
    u_pins.ex_fall();
    repeat (4) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_RCAPH, 8'h12);
    rdc(tcu_pkg::ADDR_T2CTRL, 8'h4d);
    chk({7'h0, third_irq_o}, 8'h01);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h00);
    wr(tcu_pkg::ADDR_T2MODE, 8'h01);
    wr(tcu_pkg::ADDR_RCAPH, 8'h10);
    wr(tcu_pkg::ADDR_RCAPL, 8'h00);
    wr(tcu_pkg::ADDR_TH2, 8'h10);
    wr(tcu_pkg::ADDR_TL2, 8'h01);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h04);
    repeat (40) @(posedge clk_sys);
    rdc(tcu_pkg::ADDR_TH2, 8'hff);
    rdc(tcu_pkg::ADDR_T2CTRL, 8'hc4);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h40);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, third_irq_o}, 8'h00);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h00);
    wr(tcu_pkg::ADDR_T2MODE, 8'h02);
    wr(tcu_pkg::ADDR_RCAPH, 8'hff);
    wr(tcu_pkg::ADDR_RCAPL, 8'hfc);
    wr(tcu_pkg::ADDR_TH2, 8'hff);
    wr(tcu_pkg::ADDR_TL2, 8'hfc);
    wr(tcu_pkg::ADDR_T2CTRL, 8'h04);
    for (int i = 0; i < 2; i++) begin
      wr(tcu_pkg::ADDR_SYSCFG, {7'h0, i[0]});
      @(posedge clock_out_o);
      t_a = cyc;
      @(posedge clock_out_o);
      chk(8'(cyc - t_a), (i == 1) ? 8'h08 : 8'h10);
    end
    chk({7'h0, clock_out_oe}, 8'h01);
    rdc(tcu_pkg::ADDR_T2CTRL, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(tcu_pkg::ADDR_SYSCFG, pw[i]);
      repeat (2) @(posedge clk_sys);
      chk({4'h0, addr_latch_strobe_o, program_store_strobe_o, port0_float_o, port2_addr_o},
          {4'h0, pe[i]});
    end
    test_done();
  end
endmodule : three_timer_counter_unit_bench

`default_nettype wire
